//--- rtl/aopm_pkg.sv
// constants shared by the output port pin multiplexer
package aopm_pkg;
    localparam int NUM_CH    = 6;
    localparam int WORD_W    = 16;
    localparam int PIN_W     = 16;
    localparam int NUM_LINES = 3;
    localparam int TOTAL_BITS = NUM_CH * WORD_W;

    // pin positions of the shared port
    localparam int PIN_SEL_A   = 0;
    localparam int PIN_CHAIN_C = 3;
    localparam int PIN_SCLK    = 6;
    localparam int PIN_BIT7    = 7;
    localparam int PIN_DOUT_A  = 8;
    localparam int PIN_PAR_LO  = 2;
    localparam int PIN_PAR_HI  = 8;

    // register map
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_RESULT0 = 8'h10;
    localparam logic [7:0] ADDR_RESULT5 = 8'h24;

    // control fields and reset value
    localparam int CTRL_DRIVE_EN = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // status fields
    localparam int ST_SERIAL   = 0;
    localparam int ST_CHAIN_EN = 1;
    localparam int ST_SEL_LO   = 2;
    localparam int ST_FRAME    = 5;
    localparam int ST_BYTE_ORD = 6;
    localparam int ST_PHASE    = 7;
    localparam int ST_PTR_LO   = 8;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- rtl/aopm_ser_if.sv
// carrier between the register side and the serial link logic
`timescale 1ns/1ps
`default_nettype none
interface aopm_ser_if;
    logic [aopm_pkg::WORD_W-1:0]    bank [aopm_pkg::NUM_CH];
    logic [aopm_pkg::NUM_LINES-1:0] sel;
    logic                           chain_en;
    logic [aopm_pkg::NUM_LINES-1:0] chain_in;
    logic [aopm_pkg::NUM_LINES-1:0] dout;

    modport top (output bank, output sel, output chain_en, output chain_in, input dout);
    modport ser (input bank, input sel, input chain_en, input chain_in, output dout);
endinterface
`default_nettype wire

//--- rtl/aopm_sync.sv
// two flip-flop synchroniser for pin levels
`timescale 1ns/1ps
`default_nettype none
module aopm_sync #(
    parameter int         W     = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    // first stage feeds only the second
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            meta_r <= INIT;
            q      <= INIT;
        end
        else
        begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule
`default_nettype wire

//--- rtl/aopm_serial_out.sv
// serial output lines and chain pass-through on the host serial clock
`timescale 1ns/1ps
`default_nettype none
module aopm_serial_out (
    input  wire logic sclk,
    input  wire logic xfer_sel_n,
    aopm_ser_if.ser   sif
);
    logic [7:0] cnt_r;
    logic [aopm_pkg::NUM_LINES-1:0] chain_q_r;
    logic [7:0] own_len;

    // bits per line shrink as more lines are turned on
    always_comb
    begin
        if (sif.sel[2])
            own_len = 8'(aopm_pkg::TOTAL_BITS / 3);
        else if (sif.sel[1])
            own_len = 8'(aopm_pkg::TOTAL_BITS / 2);
        else
            own_len = 8'(aopm_pkg::TOTAL_BITS);
    end

    // bit counter, cleared while the frame is idle, steps on falling clock
    always_ff @(negedge sclk or posedge xfer_sel_n)
    begin
        if (xfer_sel_n)
            cnt_r <= 8'h00;
        else if (cnt_r != 8'hff)
            cnt_r <= cnt_r + 8'h01;
    end

    // upstream chain data taken on rising clock
    always_ff @(posedge sclk or posedge xfer_sel_n)
    begin
        if (xfer_sel_n)
            chain_q_r <= '0;
        else
            chain_q_r <= sif.chain_in;
    end

    // own words first, most significant bit at frame start, then chain data
    always_comb
    begin
        int idx;
        idx = 0;
        for (int k = 0; k < aopm_pkg::NUM_LINES; k++)
        begin
            idx = k * int'(own_len) + int'(cnt_r);
            if (cnt_r < own_len && idx < aopm_pkg::TOTAL_BITS)
                sif.dout[k] = sif.bank[idx / 16][15 - (idx % 16)];
            else
                sif.dout[k] = sif.chain_en & chain_q_r[k];
        end
    end

    a_msb_first: assert property (@(negedge sclk) disable iff (xfer_sel_n)
        (cnt_r == 8'h00) |-> (sif.dout[0] == sif.bank[0][15]))
        else $error("first serial bit is not the msb of channel 0");
    a_chain_pass: assert property (@(negedge sclk) disable iff (xfer_sel_n)
        (cnt_r >= own_len && sif.chain_en) |-> (sif.dout == chain_q_r))
        else $error("chain data not passed after own bits");
endmodule
`default_nettype wire

//--- rtl/aopm_pin_mux.sv
// output port pin multiplexer with register access over axi4-lite
`timescale 1ns/1ps
`default_nettype none
module aopm_pin_mux (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        serial_clk,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic        interface_mode_select,
    input  wire logic        word_byte_select,
    input  wire logic        transfer_select_n,
    input  wire logic        read_strobe_n,
    input  wire logic [15:0] db_in,
    output logic      [15:0] db_out,
    output logic      [15:0] db_oe
);
    aopm_ser_if sif ();

    logic [3:0]  pins_s;
    logic [3:0]  cfg_s;
    logic        ser_mode_r;
    logic        byte_mode_r;
    logic        cs_s;
    logic        rd_s;
    logic        rd_d_r;
    logic        byte_ord;
    logic [2:0]  sel_r;
    logic        chain_en_r;
    logic [31:0] ctrl_r;
    logic [15:0] bank_r [aopm_pkg::NUM_CH];
    logic [2:0]  ptr_r;
    logic        phase_r;
    logic [15:0] out_r;
    logic [15:0] cur_word;
    logic        reading;
    logic        frame;
    logic [7:0]  aw_addr_r;
    logic        aw_held_r;
    logic [31:0] w_data_r;
    logic [3:0]  w_strb_r;
    logic        w_held_r;
    logic        wr_go;

    // pin levels into the system clock domain
    aopm_sync #(.W(4), .INIT(4'b0011)) u_sync_ctl (
        .clk (clk),
        .rst (rst),
        .d   ({word_byte_select, interface_mode_select, read_strobe_n, transfer_select_n}),
        .q   (pins_s)
    );
    aopm_sync #(.W(4), .INIT(4'b0000)) u_sync_cfg (
        .clk (clk),
        .rst (rst),
        .d   ({db_in[aopm_pkg::PIN_BIT7], db_in[aopm_pkg::PIN_SEL_A +: 3]}),
        .q   (cfg_s)
    );

    assign cs_s     = pins_s[0];
    assign rd_s     = pins_s[1];
    assign byte_ord = cfg_s[3];
    assign frame    = ser_mode_r & ~cs_s;
    assign cur_word = bank_r[ptr_r];
    assign reading  = ~ser_mode_r & ~cs_s & ~rd_s & ctrl_r[aopm_pkg::CTRL_DRIVE_EN];

    // mode and serial setup held steady while a serial frame runs
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ser_mode_r  <= 1'b0;
            byte_mode_r <= 1'b0;
            sel_r       <= 3'b000;
            chain_en_r  <= 1'b0;
        end
        else if (!frame)
        begin
            ser_mode_r  <= pins_s[2];
            byte_mode_r <= pins_s[3];
            sel_r       <= cfg_s[2:0];
            chain_en_r  <= cfg_s[3];
        end
    end

    // parallel read pointer, one step per read strobe release in word mode, per second release in byte mode
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rd_d_r  <= 1'b1;
            ptr_r   <= 3'd0;
            phase_r <= 1'b0;
        end
        else
        begin
            rd_d_r <= rd_s;
            if (cs_s || ser_mode_r)
            begin
                ptr_r   <= 3'd0;
                phase_r <= 1'b0;
            end
            else if (rd_s && !rd_d_r)
            begin
                phase_r <= byte_mode_r ? ~phase_r : 1'b0;
                if (!byte_mode_r || phase_r)
                    ptr_r <= (ptr_r == 3'(aopm_pkg::NUM_CH - 1)) ? 3'd0 : ptr_r + 3'd1;
            end
        end
    end

    // parallel output word, byte order chosen by pin 7 in byte mode
    always_ff @(posedge clk)
    begin
        if (rst)
            out_r <= 16'h0000;
        else if (byte_mode_r)
            out_r <= {(byte_ord ^ phase_r) ? cur_word[15:8] : cur_word[7:0], 8'h00};
        else
            out_r <= cur_word;
    end

    // pin drive: parallel word, parallel byte, or serial lines
    always_comb
    begin
        db_out = out_r;
        db_oe  = 16'h0000;
        if (!ser_mode_r)
        begin
            if (reading)
                db_oe = byte_mode_r ? 16'hff00 : 16'hffff;
        end
        else
        begin
            db_out = 16'h0000;
            for (int k = 0; k < aopm_pkg::NUM_LINES; k++)
            begin
                db_out[aopm_pkg::PIN_DOUT_A + k] = sif.dout[k];
                db_oe[aopm_pkg::PIN_DOUT_A + k]  = sel_r[k] & ~transfer_select_n;
            end
        end
    end

    // feed the link logic; bank and setup stay frozen during a frame
    assign sif.sel      = sel_r;
    assign sif.chain_en = chain_en_r;
    assign sif.chain_in = {db_in[aopm_pkg::PIN_CHAIN_C], db_in[aopm_pkg::PIN_CHAIN_C + 1],
                           db_in[aopm_pkg::PIN_CHAIN_C + 2]};
    generate
        for (genvar g = 0; g < aopm_pkg::NUM_CH; g++)
        begin : g_bank
            assign sif.bank[g] = bank_r[g];
        end
    endgenerate

    aopm_serial_out u_ser (
        .sclk       (serial_clk),
        .xfer_sel_n (transfer_select_n),
        .sif        (sif)
    );

    // write address and data accepted in either order
    assign s_axi_awready = ~aw_held_r;
    assign s_axi_wready  = ~w_held_r;
    assign wr_go         = aw_held_r & w_held_r & ~s_axi_bvalid & ~frame;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            aw_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
        end
        else if (s_axi_awvalid && !aw_held_r)
        begin
            aw_held_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
        end
        else if (wr_go)
            aw_held_r <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            w_held_r <= 1'b0;
            w_data_r <= 32'h0000_0000;
            w_strb_r <= 4'h0;
        end
        else if (s_axi_wvalid && !w_held_r)
        begin
            w_held_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
        end
        else if (wr_go)
            w_held_r <= 1'b0;
    end

    // register writes and write response
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ctrl_r       <= aopm_pkg::CTRL_RESET;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= aopm_pkg::RESP_OKAY;
            for (int i = 0; i < aopm_pkg::NUM_CH; i++)
                bank_r[i] <= 16'h0000;
        end
        else if (wr_go)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= aopm_pkg::RESP_OKAY;
            if (aw_addr_r == aopm_pkg::ADDR_CTRL)
            begin
                if (w_strb_r[0])
                    ctrl_r[7:0] <= w_data_r[7:0];
            end
            else if (aw_addr_r >= aopm_pkg::ADDR_RESULT0 && aw_addr_r <= aopm_pkg::ADDR_RESULT5
                     && aw_addr_r[1:0] == 2'b00)
            begin
                if (w_strb_r[0])
                    bank_r[3'((aw_addr_r - aopm_pkg::ADDR_RESULT0) >> 2)][7:0] <= w_data_r[7:0];
                if (w_strb_r[1])
                    bank_r[3'((aw_addr_r - aopm_pkg::ADDR_RESULT0) >> 2)][15:8] <= w_data_r[15:8];
            end
            else if (aw_addr_r != aopm_pkg::ADDR_STATUS)
                s_axi_bresp <= aopm_pkg::RESP_SLVERR;
        end
        else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end

    // read channel, answer one cycle after the address is taken
    assign s_axi_arready = ~s_axi_rvalid;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= aopm_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && !s_axi_rvalid)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= aopm_pkg::RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
            if (s_axi_araddr == aopm_pkg::ADDR_CTRL)
                s_axi_rdata <= ctrl_r;
            else if (s_axi_araddr == aopm_pkg::ADDR_STATUS)
            begin
                s_axi_rdata[aopm_pkg::ST_SERIAL]              <= ser_mode_r;
                s_axi_rdata[aopm_pkg::ST_CHAIN_EN]            <= chain_en_r;
                s_axi_rdata[aopm_pkg::ST_SEL_LO +: 3]         <= sel_r;
                s_axi_rdata[aopm_pkg::ST_FRAME]               <= frame;
                s_axi_rdata[aopm_pkg::ST_BYTE_ORD]            <= byte_ord;
                s_axi_rdata[aopm_pkg::ST_PHASE]               <= phase_r;
                s_axi_rdata[aopm_pkg::ST_PTR_LO +: 3]         <= ptr_r;
            end
            else if (s_axi_araddr >= aopm_pkg::ADDR_RESULT0 && s_axi_araddr <= aopm_pkg::ADDR_RESULT5
                     && s_axi_araddr[1:0] == 2'b00)
                s_axi_rdata[15:0] <= bank_r[3'((s_axi_araddr - aopm_pkg::ADDR_RESULT0) >> 2)];
            else
                s_axi_rresp <= aopm_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

    a_par_drive: assert property (@(posedge clk) disable iff (rst)
        reading |-> (&db_oe[aopm_pkg::PIN_PAR_HI:aopm_pkg::PIN_PAR_LO] || byte_mode_r))
        else $error("parallel pins not driven during read");
    a_line_c_off: assert property (@(posedge clk) disable iff (rst)
        (ser_mode_r && !sel_r[2]) |-> !db_oe[aopm_pkg::PIN_DOUT_A + 2])
        else $error("line c driven while not selected");
    a_chain_inputs: assert property (@(posedge clk) disable iff (rst)
        (ser_mode_r && chain_en_r) |-> (db_oe[5:3] == 3'b000))
        else $error("chain input pins driven");
    a_sclk_input: assert property (@(posedge clk) disable iff (rst)
        ser_mode_r |-> !db_oe[aopm_pkg::PIN_SCLK])
        else $error("serial clock pin driven");
    a_word_bit7: assert property (@(posedge clk) disable iff (rst)
        (reading && !byte_mode_r && $stable(ptr_r) && $stable(byte_mode_r))
        |-> (db_oe[7] && db_out[7] == $past(cur_word[7])))
        else $error("bit 7 not a data bit in word mode");
    a_byte_order: assert property (@(posedge clk) disable iff (rst)
        (reading && byte_mode_r && !phase_r) ##1 (byte_mode_r && $stable(ptr_r) && $stable(byte_ord))
        |-> (db_out[15:8] == (byte_ord ? $past(cur_word[15:8]) : $past(cur_word[7:0]))
             && !db_oe[7]))
        else $error("first byte order wrong");
    a_dout_a_on: assert property (@(posedge clk) disable iff (rst)
        (ser_mode_r && sel_r[0] && !transfer_select_n) |-> db_oe[aopm_pkg::PIN_DOUT_A])
        else $error("line a not driven");
    a_mode_follow: assert property (@(posedge clk) disable iff (rst)
        (pins_s[2] && !frame) |=> (ser_mode_r && db_oe[7:0] == 8'h00))
        else $error("serial mode not taken");
endmodule
`default_nettype wire

//--- verif/aopm_host.sv
// host model: frames serial reads and strobes parallel reads
`timescale 1ns/1ps
`default_nettype none
module aopm_host (
    input  wire logic        clk,
    input  wire logic [15:0] pin,
    input  wire logic [15:0] oe,
    output logic             sclk,
    output logic             cs_n,
    output logic             rd_n
);
    logic [95:0] cap [3];
    logic [2:0]  cap_oe;

    // idle levels: not framed, no strobe, serial clock parked high
    initial
    begin
        sclk = 1'b1;
        cs_n = 1'b1;
        rd_n = 1'b1;
    end

    // serial frame; the clock runs only inside it, lines sampled before each fall
    task automatic ser_frame(input int nbits);
        @(posedge clk);
        cs_n <= 1'b0;
        #17;
        cap_oe = oe[10:8];
        for (int i = 0; i < nbits; i++)
        begin
            for (int k = 0; k < 3; k++)
                cap[k][i] = pin[8+k];
            sclk = 1'b0;
            #15;
            sclk = 1'b1;
            #15;
        end
        @(posedge clk);
        cs_n <= 1'b1;
    endtask

    // one parallel read strobe, bus sampled while it is driven
    task automatic par_read(output logic [15:0] v, output logic [15:0] e);
        @(posedge clk);
        cs_n <= 1'b0;
        rd_n <= 1'b0;
        repeat (6) @(posedge clk);
        @(negedge clk);
        v = pin;
        e = oe;
        @(posedge clk);
        rd_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask

    // end of a parallel access rewinds the channel pointer
    task automatic par_end();
        @(posedge clk);
        cs_n <= 1'b1;
        repeat (5) @(posedge clk);
    endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// self-checking bench for the output port pin multiplexer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
    begin \
        samples_checked++; \
        if ((gt) !== (ex)) \
        begin \
            error_cnt++; \
            $display("mismatch %s expected %h seen %h", nm, ex, gt); \
        end \
    end
module tb_top;
    logic        clk, rst, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, mode, wbsel, pin7, sclk, cs_n, rd_n;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0]  bresp, rresp;
    logic [2:0]  sel, chain;
    logic [15:0] db_out, db_oe, ext, pin;
    int          error_cnt = 0;
    int          samples_checked = 0;
    logic [15:0] res [6] = '{16'ha5c3, 16'h1e7f, 16'h3c96, 16'hf00d, 16'h5aa5, 16'h8421};

    // pin levels: design drive where enabled, else board side; undriven pins 15 to 8 read low
    assign ext = {8'h00, pin7, sclk, chain, sel};
    assign pin = (db_oe & db_out) | (~db_oe & ext);

    aopm_pin_mux dut (.clk(clk), .rst(rst), .serial_clk(sclk),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .interface_mode_select(mode),
        .word_byte_select(wbsel), .transfer_select_n(cs_n), .read_strobe_n(rd_n),
        .db_in(pin), .db_out(db_out), .db_oe(db_oe));

    aopm_host host (.clk(clk), .pin(pin), .oe(db_oe), .sclk(sclk), .cs_n(cs_n),
        .rd_n(rd_n));

    // 20 MHz system clock
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // register write; address and data released as each is taken
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ao, wo, bd;
        bd = 1'b0;
        r = 2'b11;
        @(posedge clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 200 && !bd; n++)
        begin
            @(negedge clk);
            ao = awvalid && awready;
            wo = wvalid && wready;
            bd = bvalid;
            r = bresp;
            @(posedge clk);
            if (ao) awvalid <= 1'b0;
            if (wo) wvalid <= 1'b0;
            if (bd) bready <= 1'b0;
        end
        `CHK("write answer", 1'b1, bd)
    endtask

    // register read
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ao, rv;
        rv = 1'b0;
        @(posedge clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 200 && !rv; n++)
        begin
            @(negedge clk);
            ao = arvalid && arready;
            rv = rvalid;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ao) arvalid <= 1'b0;
            if (rv) rready <= 1'b0;
        end
        `CHK("read answer", 1'b1, rv)
    endtask

    // sets the mode pins and lets the synchronisers settle
    task automatic setup(input logic m, input logic wb, input logic [2:0] s,
                         input logic p7, input logic [2:0] ch);
        @(posedge clk);
        mode  <= m;
        wbsel <= wb;
        sel   <= s;
        pin7  <= p7;
        chain <= ch;
        repeat (8) @(posedge clk);
    endtask

    task automatic t_regs();
        logic [31:0] d;
        logic [1:0]  r;
        axi_rd(aopm_pkg::ADDR_CTRL, d, r);
        `CHK("ctrl reset", aopm_pkg::CTRL_RESET, d)
        axi_wr(aopm_pkg::ADDR_STATUS, 32'hffff_ffff, r);
        `CHK("status write resp", aopm_pkg::RESP_OKAY, r)
        axi_wr(8'h3c, 32'h0000_0001, r);
        `CHK("unmapped write resp", aopm_pkg::RESP_SLVERR, r)
        axi_rd(8'h3c, d, r);
        `CHK("unmapped resp", aopm_pkg::RESP_SLVERR, r)
        `CHK("unmapped data", 32'h0000_0000, d)
        for (int i = 0; i < 6; i++)
        begin
            axi_wr(aopm_pkg::ADDR_RESULT0 + 8'(4 * i), {16'h0000, res[i]}, r);
            axi_rd(aopm_pkg::ADDR_RESULT0 + 8'(4 * i), d, r);
            `CHK("result readback", {16'h0000, res[i]}, d)
        end
        $display("test regs done");
    endtask

    task automatic t_par_word();
        logic [15:0] v, e;
        logic [1:0]  r;
        setup(1'b0, 1'b0, 3'b000, 1'b0, 3'b000);
        for (int i = 0; i < 2; i++)
        begin
            host.par_read(v, e);
            `CHK("word drive", 16'hffff, e)
            `CHK("word data", res[i], v)
        end
        host.par_end();
        // drive enable cleared: a read strobe must leave the bus released
        axi_wr(aopm_pkg::ADDR_CTRL, 32'h0000_0000, r);
        host.par_read(v, e);
        `CHK("drive off", 16'h0000, e)
        host.par_end();
        axi_wr(aopm_pkg::ADDR_CTRL, aopm_pkg::CTRL_RESET, r);
        $display("test parallel word done");
    endtask

    task automatic t_par_byte();
        logic [15:0] v, e;
        for (int h = 1; h >= 0; h--)
        begin
            setup(1'b0, 1'b1, 3'b000, 1'(h), 3'b000);
            host.par_read(v, e);
            `CHK("byte drive", 16'hff00, e)
            `CHK("first byte", h ? res[0][15:8] : res[0][7:0], v[15:8])
            host.par_read(v, e);
            `CHK("second byte", h ? res[0][7:0] : res[0][15:8], v[15:8])
            host.par_end();
        end
        $display("test parallel byte done");
    endtask

    task automatic t_ser();
        logic [2:0]  cfg [3] = '{3'b001, 3'b011, 3'b111};
        logic [95:0] ex, mk;
        int          wpl;
        for (int c = 0; c < 3; c++)
        begin
            wpl = 6 / (c + 1);
            setup(1'b1, 1'b0, cfg[c], 1'b0, 3'b000);
            host.ser_frame(16 * wpl);
            `CHK("line enables", cfg[c], host.cap_oe)
            for (int k = 0; k <= c; k++)
            begin
                ex = '0;
                mk = '0;
                for (int i = 0; i < 16 * wpl; i++)
                begin
                    ex[i] = res[k * wpl + i / 16][15 - i % 16];
                    mk[i] = 1'b1;
                end
                `CHK("serial line", ex, host.cap[k] & mk)
            end
        end
        $display("test serial done");
    endtask

    task automatic t_chain();
        logic [31:0] d;
        logic [1:0]  r;
        setup(1'b1, 1'b0, 3'b111, 1'b1, 3'b101);
        axi_rd(aopm_pkg::ADDR_STATUS, d, r);
        `CHK("status", 32'(1 << aopm_pkg::ST_SERIAL | 1 << aopm_pkg::ST_CHAIN_EN | 7 << aopm_pkg::ST_SEL_LO | 1 << aopm_pkg::ST_BYTE_ORD), d)
        host.ser_frame(34);
        for (int k = 0; k < 3; k++)
            `CHK("chain pass", {2{chain[2-k]}}, host.cap[k][33:32])
        setup(1'b1, 1'b0, 3'b111, 1'b0, 3'b000);
        $display("test chain done");
    endtask

    // prints the counts and the verdict, then stops
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // reset, then the scenarios in turn
    initial
    begin
        {awvalid, wvalid, bready, arvalid, rready, mode, wbsel, pin7} = '0;
        {awaddr, araddr, wdata, sel, chain} = '0;
        rst = 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        repeat (3) @(posedge clk);
        t_regs();
        t_par_word();
        t_par_byte();
        t_ser();
        t_chain();
        complete_run();
    end

    // watchdog against a hung handshake
    initial
    begin
        #500_000;
        `CHK("run finished", 1'b1, 1'b0)
        complete_run();
    end
endmodule
`default_nettype wire
